// ==== dv/aspm_l1_ctrl_bench.sv ====
// self-checking bench for the L1 entry and exit control
`timescale 1ns/1ps
`default_nettype none
module aspm_l1_ctrl_bench;
	logic clk, arst_n, clk_en, role, usp_exit, ask, stray;
	aspm_l1_pkg::port_cond_t cond;
	aspm_l1_pkg::partition_t part;
	logic [1:0] link_state;
	logic p_req, p_ack, p_nak, acc, rej, req, ent, l0s, ex;
	logic e_acc, e_rej, e_ex, ok_dn, ok_up;
	int run, fails, compares;
	aspm_l1_ctrl dut_u (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .role_upstream(role),
		.cond(cond), .part(part), .usp_exit_start(usp_exit), .link_state(link_state),
		.partner_l1_req(p_req), .partner_ack(p_ack), .partner_nak(p_nak), .accept_q(acc),
		.reject_q(rej), .l1_req_q(req), .l1_enter_q(ent), .l0s_try_q(l0s), .exit_start_q(ex));
	aspm_l1_partner peer_u (.clk(clk), .arst_n(arst_n), .ask(ask), .stray(stray),
		.l1_req_q(req), .partner_l1_req(p_req), .partner_ack(p_ack), .partner_nak(p_nak));
	// model conditions for either role
	assign ok_dn = cond.l1_enable && !cond.tlp_pending && !cond.ack_nak_pending;
	assign ok_up = cond.l1_enable && part.all_dsp_in_l1 && !cond.tlp_pending && !cond.dllp_pending
		&& cond.replay_empty && !cond.rx_activity && cond.credits_full && link_state <= 2'h1;
	// reference model, frozen with the design when clk_en is low
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{e_acc, e_rej, e_ex} <= 3'h0;
			run <= 0;
		end else if (clk_en) begin
			e_acc <= !role && p_req && ok_dn;
			e_rej <= !role && p_req && !ok_dn;
			e_ex <= !role && link_state == aspm_l1_pkg::LINK_L1 && (cond.tlp_pending || usp_exit);
			run <= (role && ok_up) ? run + 1 : 0;
		end
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [5:0] got, input logic [5:0] exp);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask
	// hold mode keeps the upstream idle except one broken cycle midway
	task automatic run_test(input logic r, input int n, input logic hold);
		logic [15:0] b;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			check({acc, rej, ex, req, ent, l0s}, {e_acc, e_rej, e_ex, run >= aspm_l1_pkg::QUAL_CYCLES, 2'h0});
			b = 16'($urandom);
			role <= r;
			clk_en <= hold | b[0] | b[1];
			cond <= hold ? aspm_l1_pkg::port_cond_t'({5'h11, i == n / 2, 1'b1}) : b[8:2];
			part <= hold ? 2'h2 : b[10:9];
			link_state <= hold ? aspm_l1_pkg::LINK_L0 : b[12:11];
			usp_exit <= b[13];
			ask <= b[14];
			stray <= b[15];
		end
		$display("test role=%0d hold=%0d done", r, hold);
	endtask
	task automatic give_verdict;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		{arst_n, clk_en, role, usp_exit, ask, stray} = 6'h0;
		cond = '0;
		part = '0;
		link_state = 2'h0;
		fails = 0;
		compares = 0;
		repeat (10) @(posedge clk);
		#1 arst_n = 1'b1;
		void'($urandom(65));
		run_test(1'b0, 3000, 1'b0);
		run_test(1'b1, 3000, 1'b0);
		run_test(1'b1, 40000, 1'b0 | 1'b1);
		give_verdict();
	end
endmodule
`default_nettype wire

// ==== dv/aspm_l1_partner.sv ====
// link partner model: raises L1 requests and answers ours
`timescale 1ns/1ps
`default_nettype none
module aspm_l1_partner (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// bench knobs
	input wire logic ask,
	input wire logic stray,
	// device side
	input wire logic l1_req_q,
	output logic partner_l1_req,
	output logic partner_ack,
	output logic partner_nak
);
	logic [1:0] age_q;
	logic flip_q;
	// slow answer: ack once our request has stood four cycles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{partner_l1_req, partner_ack, partner_nak, flip_q, age_q} <= '0;
		end else begin
			age_q <= l1_req_q ? age_q + 2'h1 : 2'h0;
			flip_q <= ~flip_q;
			partner_l1_req <= ask;
			// stray answers only when the bench commands them
			partner_ack <= (l1_req_q && age_q == 2'h3) || (stray && flip_q);
			partner_nak <= stray && !flip_q;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/aspm_l1_ctrl.sv ====
// L1 entry, acceptance and exit control for one switch port
// Functional notes
// - downstream accepts only when enabled and idle
// - downstream rejects any request it cannot accept
// - no L1 without link control enable
// - upstream qualifies conditions for 1 ms
// - then requests L1 from partner in L0/L0s
// - enters L1 only on partner acknowledge
// - no acknowledge: fall back to L0s attempt
// - all active downstream ports must be L1
// - no pending transaction packets required
// - upstream needs empty replay buffer
// - upstream needs no pending link packets
// - upstream receiver idle whole interval
// - upstream needs full flow control credits
// - upstream exits L1 on scheduled packet
// - upstream exits when downstream port exits
// - downstream-to-upstream exit within 1 us
// - downstream exits on packet or upstream exit
// - upstream-to-downstream exit within 1 us
`timescale 1ns/1ps
`default_nettype none
module aspm_l1_ctrl (
	// clock, reset and freeze
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// port role: high for upstream-facing
	input wire logic role_upstream,
	// local conditions and partition view
	input wire aspm_l1_pkg::port_cond_t cond,
	input wire aspm_l1_pkg::partition_t part,
	input wire logic usp_exit_start,
	// current link state from the physical layer
	input wire logic [1:0] link_state,
	// downstream role: partner request arrives
	input wire logic partner_l1_req,
	// upstream role: partner answer to our request
	input wire logic partner_ack,
	input wire logic partner_nak,
	// downstream role answers
	output logic accept_q,
	output logic reject_q,
	// upstream role requests
	output logic l1_req_q,
	output logic l1_enter_q,
	output logic l0s_try_q,
	// exit start pulse, either role
	output logic exit_start_q
);
	// upstream sequencer states
	typedef enum logic [3:0] {
		ST_QUAL = 4'h1,
		ST_REQ = 4'h2,
		ST_L1 = 4'h4,
		ST_DS = 4'h8
	} ust_t;

	ust_t st_q;
	ust_t st_d;
	logic [aspm_l1_pkg::QUAL_CNT_W-1:0] qual_cnt_q;
	logic entry_ok;
	logic qual_done;
	logic in_l0_l0s;
	logic us_exit;
	logic ds_exit;

	// every upstream entry condition except the L0/L0s link state, at once
	assign entry_ok = cond.l1_enable
		&& part.all_dsp_in_l1
		&& !cond.tlp_pending
		&& cond.replay_empty
		&& !cond.dllp_pending
		&& !cond.rx_activity
		&& cond.credits_full;
	assign qual_done = (qual_cnt_q ==
		aspm_l1_pkg::QUAL_CNT_W'(aspm_l1_pkg::QUAL_CYCLES - 1));
	assign in_l0_l0s = (link_state == aspm_l1_pkg::LINK_L0) ||
		(link_state == aspm_l1_pkg::LINK_L0S);
	// exit decided combinationally so the start pulse is one cycle later
	assign us_exit = cond.tlp_pending || part.dsp_exit_start;
	assign ds_exit = cond.tlp_pending || usp_exit_start;

	// interval counter, cleared when any condition in entry_ok breaks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			qual_cnt_q <= '0;
		end else if (clk_en) begin
			if (st_q != ST_QUAL || !entry_ok) begin
				qual_cnt_q <= '0;
			end else if (!qual_done) begin
				qual_cnt_q <= qual_cnt_q + 1'b1;
			end
		end
	end

	// next state for the upstream role; downstream role parks in ST_DS
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_QUAL: begin
				if (!role_upstream) begin
					st_d = ST_DS;
				end else if (qual_done && entry_ok && in_l0_l0s) begin
					st_d = ST_REQ;
				end
			end
			ST_REQ: begin
				if (!role_upstream || !entry_ok) begin
					st_d = ST_QUAL;
				end else if (partner_ack) begin
					st_d = ST_L1;
				end else if (partner_nak) begin
					st_d = ST_QUAL;
				end
			end
			ST_L1: begin
				if (!role_upstream || us_exit) begin
					st_d = ST_QUAL;
				end
			end
			ST_DS: begin
				if (role_upstream) begin
					st_d = ST_QUAL;
				end
			end
			default: st_d = ST_QUAL;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_QUAL;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// upstream role outputs: request and entry registered from the next state, L0s try from the current state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			l1_req_q <= 1'b0;
			l1_enter_q <= 1'b0;
			l0s_try_q <= 1'b0;
		end else if (clk_en) begin
			l1_req_q <= (st_d == ST_REQ);
			l1_enter_q <= (st_d == ST_L1);
			l0s_try_q <= (st_q == ST_REQ) && role_upstream && partner_nak && !partner_ack;
		end
	end

	// downstream role answers; each request gets exactly one answer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			accept_q <= 1'b0;
			reject_q <= 1'b0;
		end else if (clk_en) begin
			accept_q <= !role_upstream && partner_l1_req && cond.l1_enable
				&& !cond.tlp_pending && !cond.ack_nak_pending;
			reject_q <= !role_upstream && partner_l1_req && !(cond.l1_enable
				&& !cond.tlp_pending && !cond.ack_nak_pending);
		end
	end

	// exit start: one cycle after the cause, well inside the 1 us bound
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			exit_start_q <= 1'b0;
		end else if (clk_en) begin
			if (role_upstream) begin
				exit_start_q <= (st_q == ST_L1) && us_exit;
			end else begin
				exit_start_q <= (link_state == aspm_l1_pkg::LINK_L1) && ds_exit;
			end
		end
	end

	// assertions
	property p_accept_ok;
		@(posedge clk) disable iff (!arst_n)
		clk_en && !role_upstream && partner_l1_req && cond.l1_enable && !cond.tlp_pending
			&& !cond.ack_nak_pending |=> accept_q && !reject_q;
	endproperty
	a_accept_ok: assert property (p_accept_ok) else $error("accept missing");

	property p_reject;
		@(posedge clk) disable iff (!arst_n)
		clk_en && !role_upstream && partner_l1_req && !cond.l1_enable |=> reject_q && !accept_q;
	endproperty
	a_reject: assert property (p_reject) else $error("reject missing");

	property p_no_l1_disabled;
		@(posedge clk) disable iff (!arst_n)
		$rose(l1_req_q) |-> $past(cond.l1_enable);
	endproperty
	a_no_l1_disabled: assert property (p_no_l1_disabled) else $error("L1 while disabled");

	property p_qual;
		@(posedge clk) disable iff (!arst_n)
		$rose(l1_req_q) |-> $past(qual_cnt_q) ==
			aspm_l1_pkg::QUAL_CNT_W'(aspm_l1_pkg::QUAL_CYCLES - 1);
	endproperty
	a_qual: assert property (p_qual) else $error("request before interval");

	property p_restart;
		@(posedge clk) disable iff (!arst_n)
		clk_en && !entry_ok |=> qual_cnt_q == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("interval not restarted");

	sequence s_req_acked;
		clk_en && st_q == ST_REQ && role_upstream && entry_ok && partner_ack;
	endsequence
	property p_enter_on_ack;
		@(posedge clk) disable iff (!arst_n)
		s_req_acked |=> l1_enter_q;
	endproperty
	a_enter_on_ack: assert property (p_enter_on_ack) else $error("no L1 after ack");

	property p_enter_cause;
		@(posedge clk) disable iff (!arst_n)
		$rose(l1_enter_q) |-> $past(partner_ack);
	endproperty
	a_enter_cause: assert property (p_enter_cause) else $error("L1 without ack");

	property p_l0s_fallback;
		@(posedge clk) disable iff (!arst_n)
		clk_en && st_q == ST_REQ && role_upstream && entry_ok && partner_nak && !partner_ack
			|=> l0s_try_q ##1 !l1_req_q;
	endproperty
	a_l0s_fallback: assert property (p_l0s_fallback) else $error("no L0s fallback");

	property p_us_exit;
		@(posedge clk) disable iff (!arst_n)
		clk_en && role_upstream && st_q == ST_L1 && part.dsp_exit_start |=> exit_start_q;
	endproperty
	a_us_exit: assert property (p_us_exit) else $error("upstream exit late");

	property p_ds_exit;
		@(posedge clk) disable iff (!arst_n)
		clk_en && !role_upstream && link_state == aspm_l1_pkg::LINK_L1 && usp_exit_start
			|=> exit_start_q;
	endproperty
	a_ds_exit: assert property (p_ds_exit) else $error("downstream exit late");

	// a partner request seen in the downstream role, the start of every answer
	sequence s_ds_request;
		clk_en && !role_upstream && partner_l1_req;
	endsequence

	// the request goes out from the qualifying state in an enabled upstream role
	sequence s_req_rise;
		$rose(l1_req_q) ##0 $past(role_upstream);
	endsequence

	property p_one_answer;
		@(posedge clk) disable iff (!arst_n)
		!(accept_q && reject_q);
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("accept and reject together");

	property p_reject_tlp;
		@(posedge clk) disable iff (!arst_n)
		s_ds_request ##0 cond.tlp_pending |=> reject_q && !accept_q;
	endproperty
	a_reject_tlp: assert property (p_reject_tlp) else $error("accepted with packets queued");

	property p_reject_acknak;
		@(posedge clk) disable iff (!arst_n)
		s_ds_request ##0 cond.ack_nak_pending |=> reject_q && !accept_q;
	endproperty
	a_reject_acknak: assert property (p_reject_acknak) else $error("accepted with ack pending");

	property p_no_answer_up;
		@(posedge clk) disable iff (!arst_n)
		clk_en && role_upstream |=> !accept_q && !reject_q;
	endproperty
	a_no_answer_up: assert property (p_no_answer_up) else $error("answer in upstream role");

	property p_answer_needs_req;
		@(posedge clk) disable iff (!arst_n)
		clk_en && !partner_l1_req |=> !accept_q && !reject_q;
	endproperty
	a_answer_needs_req: assert property (p_answer_needs_req) else $error("answer without request");

	property p_req_partition;
		@(posedge clk) disable iff (!arst_n)
		s_req_rise |-> $past(part.all_dsp_in_l1);
	endproperty
	a_req_partition: assert property (p_req_partition) else $error("request with active ports");

	property p_req_tlp;
		@(posedge clk) disable iff (!arst_n)
		s_req_rise |-> !$past(cond.tlp_pending);
	endproperty
	a_req_tlp: assert property (p_req_tlp) else $error("request with packets queued");

	property p_req_replay;
		@(posedge clk) disable iff (!arst_n)
		s_req_rise |-> $past(cond.replay_empty);
	endproperty
	a_req_replay: assert property (p_req_replay) else $error("request with replay data");

	property p_req_dllp;
		@(posedge clk) disable iff (!arst_n)
		s_req_rise |-> !$past(cond.dllp_pending);
	endproperty
	a_req_dllp: assert property (p_req_dllp) else $error("request with link packets queued");

	property p_req_rx;
		@(posedge clk) disable iff (!arst_n)
		s_req_rise |-> !$past(cond.rx_activity);
	endproperty
	a_req_rx: assert property (p_req_rx) else $error("request with receiver busy");

	property p_req_credits;
		@(posedge clk) disable iff (!arst_n)
		s_req_rise |-> $past(cond.credits_full);
	endproperty
	a_req_credits: assert property (p_req_credits) else $error("request short of credits");

	property p_req_link;
		@(posedge clk) disable iff (!arst_n)
		s_req_rise |-> $past(in_l0_l0s);
	endproperty
	a_req_link: assert property (p_req_link) else $error("request outside L0 or L0s");

	property p_us_tlp_exit;
		@(posedge clk) disable iff (!arst_n)
		clk_en && role_upstream && st_q == ST_L1 && cond.tlp_pending |=> exit_start_q && !l1_enter_q;
	endproperty
	a_us_tlp_exit: assert property (p_us_tlp_exit) else $error("upstream stays in L1");

	property p_ds_tlp_exit;
		@(posedge clk) disable iff (!arst_n)
		clk_en && !role_upstream && link_state == aspm_l1_pkg::LINK_L1 && cond.tlp_pending
			|=> exit_start_q;
	endproperty
	a_ds_tlp_exit: assert property (p_ds_tlp_exit) else $error("downstream stays in L1");

	property p_l1_holds;
		@(posedge clk) disable iff (!arst_n)
		clk_en && role_upstream && st_q == ST_L1 && !us_exit |=> l1_enter_q;
	endproperty
	a_l1_holds: assert property (p_l1_holds) else $error("L1 left without cause");

	property p_ds_exit_cause;
		@(posedge clk) disable iff (!arst_n)
		$rose(exit_start_q) ##0 !$past(role_upstream)
			|-> $past(link_state) == aspm_l1_pkg::LINK_L1;
	endproperty
	a_ds_exit_cause: assert property (p_ds_exit_cause) else $error("exit outside L1");

	// a low enable must hold every flop, or counts drift while the port sleeps
	property p_freeze;
		@(posedge clk) disable iff (!arst_n)
		!clk_en |=> $stable(qual_cnt_q) && $stable(st_q)
			&& $stable({accept_q, reject_q, l1_req_q, l1_enter_q, l0s_try_q, exit_start_q});
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule
`default_nettype wire

// ==== verilog/aspm_l1_pkg.sv ====
// shared constants and carrier types for the L1 power management block
package aspm_l1_pkg;
	// qualifying interval before the upstream role requests L1
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned QUAL_TIME_US = 1000;
	localparam int unsigned QUAL_CYCLES = (QUAL_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;
	// longest allowed exit propagation between roles
	localparam int unsigned EXIT_LAT_NS = 1000;
	localparam int unsigned EXIT_LAT_CYCLES = (EXIT_LAT_NS * 1000) / CLK_PERIOD_PS;
	// width of the interval counter
	localparam int unsigned QUAL_CNT_W = 18;
	// link states as reported to the link layer
	localparam logic [1:0] LINK_L0 = 2'h0;
	localparam logic [1:0] LINK_L0S = 2'h1;
	localparam logic [1:0] LINK_L1 = 2'h2;
	localparam logic [1:0] LINK_DOWN = 2'h3;

	// port-local conditions fed by the transaction and link layers
	typedef struct packed {
		logic l1_enable;
		logic tlp_pending;
		logic ack_nak_pending;
		logic dllp_pending;
		logic replay_empty;
		logic rx_activity;
		logic credits_full;
	} port_cond_t;

	// partition view of the downstream-facing ports
	typedef struct packed {
		logic all_dsp_in_l1;
		logic dsp_exit_start;
	} partition_t;
endpackage
